/* File: hw/addr_decode_consts.vh */
// Address map constants for the memory address decoder
// Overview of operation
// - After reset the first fetch goes to address FF2080H.
// - High bank FF2000H-FF9FFFH goes to code memory or external bus per access pin.
// - Low bank 002000H-009FFFH is code memory only with code_memory_low_map_bit bit set and pin high.
// - Instruction fetches from 00000H-003FFH always go external.
// - FF0400H-FF05FFH aliases the internal RAM at 00400H-005FFH.
// - Internal RAM at 000400H-0005FFH, indirect or indexed access only.
// - CPU registers 000000H-000017H and lower register RAM to 0000FFH, any mode.
// - Upper register RAM 000100H-0003FFH, indirect, indexed or windowed.
// - Internal registers 001F00H-001FDFH, memory-mapped registers 001FE0H-001FFFH.
// - Addresses are 24 bits inside; only the low 20 reach the external bus.
`ifndef ADDR_DECODE_CONSTS_VH
`define ADDR_DECODE_CONSTS_VH
`define RESET_FETCH_ADDR 24'hff2080
`define HI_CODE_LO 24'hff2000
`define HI_CODE_HI 24'hff9fff
`define LO_CODE_LO 24'h002000
`define LO_CODE_HI 24'h009fff
`define HI_RAM_LO 24'hff0400
`define HI_RAM_HI 24'hff05ff
`define RAM_LO 24'h000400
`define RAM_HI 24'h0005ff
`define CPU_REG_LO 24'h000000
`define CPU_REG_HI 24'h000017
`define LOW_REG_LO 24'h000018
`define LOW_REG_HI 24'h0000ff
`define UP_REG_LO 24'h000100
`define UP_REG_HI 24'h0003ff
`define ISFR_LO 24'h001f00
`define ISFR_HI 24'h001fdf
`define MSFR_LO 24'h001fe0
`define MSFR_HI 24'h001fff
`define RAM_INDEX_W 9
`define REG_INDEX_W 10
`define CODE_INDEX_W 15
`define SFR_INDEX_W 8
`define EXT_ADDR_W 20
`define TGT_REG 3'd0
`define TGT_SFR 3'd1
`define TGT_RAM 3'd2
`define TGT_CODE 3'd3
`define TGT_EXT 3'd4
`define MODE_DIRECT 2'd0
`define MODE_INDIRECT 2'd1
`define MODE_INDEXED 2'd2
`define MODE_WINDOW 2'd3
`endif

/* File: hw/memory_address_decoder.v */
// Memory address decoder steering CPU accesses to internal targets or external bus
`timescale 1ns/1ps
`include "addr_decode_consts.vh"
module memory_address_decoder (
  input wire clk_i,
  input wire nrst_i,
  input wire req_valid_i,
  input wire [23:0] req_addr_i,
  input wire req_fetch_i,
  input wire req_write_i,
  input wire [1:0] req_mode_i,
  input wire code_memory_low_map_bit_i,
  input wire external_access_select_pin_i,
  output wire boot_pending_o,
  output wire [23:0] boot_addr_o,
  output reg dec_valid_o,
  output reg [2:0] dec_target_o,
  output reg dec_fetch_o,
  output reg dec_write_o,
  output reg dec_mode_fault_o,
  output reg [`REG_INDEX_W-1:0] reg_index_o,
  output reg [`SFR_INDEX_W-1:0] sfr_index_o,
  output reg sfr_mapped_o,
  output reg [`RAM_INDEX_W-1:0] ram_index_o,
  output reg [`CODE_INDEX_W-1:0] code_index_o,
  output reg [`EXT_ADDR_W-1:0] ext_addr_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Range test
  function in_range;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Claimed windows, one bit each
  localparam NUM_REGIONS = 9;
  localparam [8:0] RGN_CPU_REG = 9'h001;
  localparam [8:0] RGN_LOW_REG = 9'h002;
  localparam [8:0] RGN_UP_REG = 9'h004;
  localparam [8:0] RGN_RAM = 9'h008;
  localparam [8:0] RGN_ISFR = 9'h010;
  localparam [8:0] RGN_MSFR = 9'h020;
  localparam [8:0] RGN_LO_CODE = 9'h040;
  localparam [8:0] RGN_HI_RAM = 9'h080;
  localparam [8:0] RGN_HI_CODE = 9'h100;

  //////////////////////////////////////////////////////////////////////////////
  // Window bounds
  // Lower bound of each window
  function [23:0] region_lo;
    input integer idx;
    begin
      case (idx)
        0: region_lo = `CPU_REG_LO;
        1: region_lo = `LOW_REG_LO;
        2: region_lo = `UP_REG_LO;
        3: region_lo = `RAM_LO;
        4: region_lo = `ISFR_LO;
        5: region_lo = `MSFR_LO;
        6: region_lo = `LO_CODE_LO;
        7: region_lo = `HI_RAM_LO;
        default: region_lo = `HI_CODE_LO;
      endcase
    end
  endfunction

  // Upper bound of each window
  function [23:0] region_hi;
    input integer idx;
    begin
      case (idx)
        0: region_hi = `CPU_REG_HI;
        1: region_hi = `LOW_REG_HI;
        2: region_hi = `UP_REG_HI;
        3: region_hi = `RAM_HI;
        4: region_hi = `ISFR_HI;
        5: region_hi = `MSFR_HI;
        6: region_hi = `LO_CODE_HI;
        7: region_hi = `HI_RAM_HI;
        default: region_hi = `HI_CODE_HI;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Window policy
  // Target of a claimed window
  function [2:0] target_of;
    input [8:0] region;
    input fetch;
    input code_memory_low_map_bit;
    input ea;
    begin
      case (region)
        RGN_CPU_REG, RGN_LOW_REG: begin
          if (fetch) begin
            target_of = `TGT_EXT;
          end else begin
            target_of = `TGT_REG;
          end
        end
        RGN_UP_REG: begin
          if (fetch) begin
            target_of = `TGT_EXT;
          end else begin
            target_of = `TGT_REG;
          end
        end
        RGN_RAM: target_of = `TGT_RAM;
        RGN_ISFR, RGN_MSFR: target_of = `TGT_SFR;
        RGN_LO_CODE: begin
          if (code_memory_low_map_bit && ea) begin
            target_of = `TGT_CODE;
          end else begin
            target_of = `TGT_EXT;
          end
        end
        RGN_HI_RAM: target_of = `TGT_RAM;
        RGN_HI_CODE: begin
          if (ea) begin
            target_of = `TGT_CODE;
          end else begin
            target_of = `TGT_EXT;
          end
        end
        // Unclaimed addresses leave the chip
        default: target_of = `TGT_EXT;
      endcase
    end
  endfunction

  // Addressing mode not allowed for the window
  function fault_of;
    input [8:0] region;
    input [1:0] mode;
    input fetch;
    begin
      case (region)
        RGN_RAM: begin
          if (fetch) begin
            fault_of = 1'b0;
          end else begin
            fault_of = (mode != `MODE_INDIRECT) && (mode != `MODE_INDEXED);
          end
        end
        RGN_UP_REG: begin
          if (fetch) begin
            fault_of = 1'b0;
          end else begin
            fault_of = (mode == `MODE_DIRECT);
          end
        end
        RGN_CPU_REG, RGN_LOW_REG: fault_of = 1'b0;
        default: fault_of = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Address fields
  function [`REG_INDEX_W-1:0] reg_index_of;
    input [23:0] a;
    begin
      reg_index_of = a[`REG_INDEX_W-1:0];
    end
  endfunction

  function [`SFR_INDEX_W-1:0] sfr_index_of;
    input [23:0] a;
    reg [23:0] offset;
    begin
      offset = a - `ISFR_LO;
      sfr_index_of = offset[`SFR_INDEX_W-1:0];
    end
  endfunction

  function sfr_mapped_of;
    input [23:0] a;
    begin
      sfr_mapped_of = (a >= `MSFR_LO);
    end
  endfunction

  // Both RAM windows fold onto one set of cells
  function [`RAM_INDEX_W-1:0] ram_index_of;
    input [23:0] a;
    reg [23:0] offset;
    begin
      if (a >= `HI_RAM_LO) begin
        offset = a - `HI_RAM_LO;
      end else begin
        offset = a - `RAM_LO;
      end
      ram_index_of = offset[`RAM_INDEX_W-1:0];
    end
  endfunction

  function [`CODE_INDEX_W-1:0] code_index_of;
    input [23:0] a;
    reg [23:0] offset;
    begin
      offset = a - `LO_CODE_LO;
      code_index_of = offset[`CODE_INDEX_W-1:0];
    end
  endfunction

  // Only the low address lines leave the chip
  function [`EXT_ADDR_W-1:0] ext_addr_of;
    input [23:0] a;
    begin
      ext_addr_of = a[`EXT_ADDR_W-1:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin and reset fetch
  wire ea_level;
  wire boot_pending;
  pin_sync u_ea_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(external_access_select_pin_i),
    .level_o(ea_level)
  );
  reset_fetch u_boot (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .first_taken_i(req_valid_i & req_fetch_i),
    .pending_o(boot_pending)
  );
  assign boot_pending_o = boot_pending;
  assign boot_addr_o = `RESET_FETCH_ADDR;

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [NUM_REGIONS-1:0] region_hit;
  reg [2:0] next_target;
  reg next_fault;
  genvar g;

  // One compare per window
  generate
    for (g = 0; g < NUM_REGIONS; g = g + 1) begin : g_region
      assign region_hit[g] = in_range(req_addr_i, region_lo(g), region_hi(g));
    end
  endgenerate

  // Windows are disjoint, so at most one bit is set
  always @* begin
    next_target = target_of(region_hit, req_fetch_i, code_memory_low_map_bit_i, ea_level);
    next_fault = fault_of(region_hit, req_mode_i, req_fetch_i);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strobe copies, one cycle behind the request
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      dec_valid_o <= 1'b0;
      dec_fetch_o <= 1'b0;
      dec_write_o <= 1'b0;
    end else begin
      dec_valid_o <= req_valid_i;
      dec_fetch_o <= req_fetch_i;
      dec_write_o <= req_write_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode result, held until the next request
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      dec_target_o <= `TGT_EXT;
      dec_mode_fault_o <= 1'b0;
    end else if (req_valid_i) begin
      dec_target_o <= next_target;
      dec_mode_fault_o <= next_fault;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address fields, held until the next request
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_index_o <= {`REG_INDEX_W{1'b0}};
      sfr_index_o <= {`SFR_INDEX_W{1'b0}};
      sfr_mapped_o <= 1'b0;
      ram_index_o <= {`RAM_INDEX_W{1'b0}};
      code_index_o <= {`CODE_INDEX_W{1'b0}};
      ext_addr_o <= {`EXT_ADDR_W{1'b0}};
    end else if (req_valid_i) begin
      reg_index_o <= reg_index_of(req_addr_i);
      sfr_index_o <= sfr_index_of(req_addr_i);
      sfr_mapped_o <= sfr_mapped_of(req_addr_i);
      ram_index_o <= ram_index_of(req_addr_i);
      code_index_o <= code_index_of(req_addr_i);
      ext_addr_o <= ext_addr_of(req_addr_i);
    end
  end
endmodule

/* File: hw/pin_sync.v */
// Three-stage synchroniser for a pin level
`timescale 1ns/1ps
module pin_sync (
  input wire clk_i,
  input wire nrst_i,
  input wire pin_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

/* File: hw/reset_fetch.v */
// Reset fetch pending flag generator
`timescale 1ns/1ps
`include "addr_decode_consts.vh"
module reset_fetch (
  input wire clk_i,
  input wire nrst_i,
  input wire first_taken_i,
  output reg pending_o
);
  // Raised during reset until the first fetch is taken
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pending_o <= 1'b1;
    end else if (first_taken_i) begin
      pending_o <= 1'b0;
    end
  end
endmodule

/* File: test/cpu_core_model.sv */
// CPU core model issuing one access at a time
`timescale 1ns/1ps
module cpu_core_model (
  input wire clk_i,
  output logic req_valid_o = 1'b0,
  output logic [23:0] req_addr_o = 24'h0,
  output logic req_fetch_o = 1'b0,
  output logic [1:0] req_mode_o = 2'h0
);
  task acc(logic [23:0] a, logic f, logic [1:0] m);
    @(negedge clk_i);
    {req_valid_o, req_addr_o, req_fetch_o, req_mode_o} = {1'b1, a, f, m};
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_addr_o = ~a;
  endtask
endmodule

/* File: test/memory_address_decoder_chk.sv */
// Decoder port checker
`timescale 1ns/1ps
module memory_address_decoder_chk (
  input wire clk_i,
  input wire nrst_i,
  input wire req_valid_i,
  input wire [23:0] req_addr_i,
  input wire req_fetch_i,
  input wire [23:0] boot_addr_o,
  input wire [2:0] dec_target_o,
  input wire sfr_mapped_o,
  input wire [8:0] ram_index_o,
  input wire [19:0] ext_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire v = req_valid_i;
  wire [23:0] a = req_addr_i;
  wire [2:0] t = dec_target_o;
  boot_addr_a: assert property (boot_addr_o == 24'hff2080) else $error("boot");
  low_fetch_a: assert property (v && req_fetch_i && a < 24'h400 |=> t == 3'd4) else $error("fetch");
  reg_file_a: assert property (v && !req_fetch_i && a < 24'h400 |=> t == 3'd0) else $error("reg");
  ram_low_a: assert property (v && a[23:9] == 15'h2 |=> t == 3'd2) else $error("ram");
  ram_alias_a: assert property (v && a[23:9] == 15'h7f82 |=> t == 3'd2 && ram_index_o == $past(a[8:0]))
    else $error("alias");
  sfr_kind_a: assert property (v && a[23:8] == 16'h1f |=> t == 3'd1 && sfr_mapped_o == &$past(a[7:5]))
    else $error("sfr");
  unclaimed_a: assert property (v && a >= 24'ha000 && a < 24'hff0000 |=> t == 3'd4) else $error("ext");
  ext_addr_a: assert property (v |=> ext_addr_o == $past(a[19:0])) else $error("addr");
endmodule

/* File: test/tb_memory_address_decoder.sv */
// Decoder bench
`timescale 1ns/1ps
module tb_memory_address_decoder;
  logic clk_i = 0, nrst_i = 0;
  logic code_memory_low_map_bit_i = 0, external_access_select_pin_i = 1;
  wire req_valid_i, req_fetch_i, boot_pending_o, dec_valid_o, dec_mode_fault_o, sfr_mapped_o;
  wire dec_fetch_o, dec_write_o;
  wire [9:0] reg_index_o;
  wire [7:0] sfr_index_o;
  wire [23:0] req_addr_i, boot_addr_o;
  wire [1:0] req_mode_i;
  wire [2:0] dec_target_o;
  wire [8:0] ram_index_o;
  wire [14:0] code_index_o;
  wire [19:0] ext_addr_o;
  wire req_write_i = ~req_fetch_i;
  int n_errors = 0, checked = 0;
  always #2.5 clk_i = ~clk_i;
  cpu_core_model cpu (.clk_i, .req_valid_o(req_valid_i), .req_addr_o(req_addr_i),
    .req_fetch_o(req_fetch_i), .req_mode_o(req_mode_i));
  memory_address_decoder DUT (.*);
  task chk(string n, logic [23:0] e, g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task mp(logic [23:0] a, logic f, logic [1:0] m, logic [2:0] t, logic x);
    cpu.acc(a, f, m);
    chk("valid", 1, dec_valid_o);
    chk("target", t, dec_target_o);
    chk("fault", x, dec_mode_fault_o);
    chk("fetch", f, dec_fetch_o);
    chk("write", !f, dec_write_o);
    chk("reg", a[9:0], reg_index_o);
    chk("sfr", a[7:0], sfr_index_o);
    chk("ext", a[19:0], ext_addr_o);
  endtask
  task pins(logic r, logic e);
    @(negedge clk_i);
    code_memory_low_map_bit_i = r;
    external_access_select_pin_i = e;
    repeat (6) @(negedge clk_i);
  endtask
  task t_boot;
    chk("pending", 1, boot_pending_o);
    mp(24'hff2080, 1, 1, 3, 0);
    chk("code", 24'h80, code_index_o);
    chk("pending", 0, boot_pending_o);
    $display("t_boot done");
  endtask
  task t_code;
    pins(1, 1);
    mp(24'h2080, 1, 1, 3, 0);
    chk("code", 24'h80, code_index_o);
    pins(0, 1);
    mp(24'h2080, 1, 1, 4, 0);
    pins(1, 0);
    mp(24'h2080, 1, 1, 4, 0);
    mp(24'hff9fff, 1, 1, 4, 0);
    chk("code", 24'h7fff, code_index_o);
    mp(24'hff2000, 1, 1, 4, 0);
    $display("t_code done");
  endtask
  task t_map;
    mp(24'h10, 0, 0, 0, 0);
    mp(24'h10, 1, 1, 4, 0);
    mp(24'h3ff, 0, 0, 0, 1);
    mp(24'h100, 0, 3, 0, 0);
    mp(24'h400, 0, 0, 2, 1);
    mp(24'h5ff, 0, 3, 2, 1);
    mp(24'hff05ff, 0, 2, 2, 0);
    chk("ram", 24'h1ff, ram_index_o);
    mp(24'h1fe0, 0, 0, 1, 0);
    chk("msfr", 1, sfr_mapped_o);
    mp(24'h1f00, 0, 0, 1, 0);
    chk("msfr", 0, sfr_mapped_o);
    mp(24'h600, 0, 1, 4, 0);
    mp(24'ha000, 0, 1, 4, 0);
    $display("t_map done");
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i = 1;
    repeat (6) @(negedge clk_i);
    t_boot;
    t_code;
    t_map;
    complete_run;
  end
  initial begin
    #5000;
    n_errors++;
    complete_run;
  end
endmodule
bind memory_address_decoder memory_address_decoder_chk chk_u (.*);
